// [bench/dbgbk_host.sv]
// Purpose: serial debug host seen as a command strobe source
// Assumes: commands change on the falling edge
// Notes:   idle data toggles so stale words are never trusted
`timescale 1ns/100ps
module dbgbk_host
   import dbgbk_pkg::*;
(
   input  wire logic  clk_i,
   output dbgbk_cmd_t  cmd_o,
   output dbgbk_addr_t wdata_o
);
   initial begin
      cmd_o   = DBGBK_CMD_NONE;
      wdata_o = 16'h0000;
   end
   // force-reset only reachable by this command path
   task automatic send(input dbgbk_cmd_t c, input dbgbk_addr_t d);
      @(negedge clk_i);
      cmd_o   = c;
      wdata_o = (c == DBGBK_CMD_NONE) ? ~wdata_o : d;
   endtask
endmodule

// [bench/dbgbk_props.sv]
// Purpose: port checker for dbgbk_top
// Assumes: one command per cycle, one breakpoint in flight
// Notes:   keeps its own shadow of the match register
`timescale 1ns/100ps
module dbgbk_props
   import dbgbk_pkg::*;
(
   input wire logic        CLK_I, SYS_RST_I, BKPT_ENABLE_I, FORCE_TAG_SEL_I, CPU_CYCLE_I,
   input wire logic        CPU_OPCODE_FETCH_I, CPU_INSTR_BOUND_I, CMD_RVALID_O,
   input wire logic        FORCE_RESET_O, TAG_OPCODE_O, BGND_REQ_O,
   input wire dbgbk_cmd_t  CMD_I,
   input wire dbgbk_addr_t CMD_WDATA_I, CPU_ADDR_I, CMD_RDATA_O,
   input wire dbgbk_byte_t FRST_RDATA_O
);
   dbgbk_addr_t bk_ff;
   logic        frst_ff;
   wire         hit = CPU_CYCLE_I && CPU_ADDR_I == bk_ff && BKPT_ENABLE_I && !BGND_REQ_O;
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bk_ff   <= 16'h0000;
         frst_ff <= 1'b0;
      end else begin
         if (CMD_I == DBGBK_CMD_WR_BKPT) bk_ff <= CMD_WDATA_I;
         frst_ff <= CMD_I == DBGBK_CMD_WR_FRST && CMD_WDATA_I[0];
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   a_read_back: assert property (CMD_I == DBGBK_CMD_RD_BKPT |=> CMD_RVALID_O && CMD_RDATA_O == bk_ff)
      else $error("read data or valid wrong");
   a_rvalid_cause: assert property (CMD_RVALID_O |-> $past(CMD_I) == DBGBK_CMD_RD_BKPT)
      else $error("valid without read");
   a_frst_zero: assert property (FRST_RDATA_O == 8'h00)
      else $error("force-reset reads nonzero");
   a_force_reset: assert property (FORCE_RESET_O == frst_ff)
      else $error("reset request wrong");
   a_force_hit: assert property (hit && FORCE_TAG_SEL_I |-> ##[1:2] BGND_REQ_O)
      else $error("no background request");
   a_tag_hit: assert property (hit && !FORCE_TAG_SEL_I ##1 CPU_OPCODE_FETCH_I |=> TAG_OPCODE_O)
      else $error("opcode not tagged");
   a_tag_pulse: assert property (TAG_OPCODE_O |=> !TAG_OPCODE_O)
      else $error("tag longer than a cycle");
   a_disabled_quiet: assert property (!BKPT_ENABLE_I [*4] |-> !TAG_OPCODE_O && !$rose(BGND_REQ_O))
      else $error("breakpoint acts while disabled");
   a_req_hold: assert property (BGND_REQ_O |=> BGND_REQ_O != $past(CPU_INSTR_BOUND_I))
      else $error("request not held to boundary");
   c_force: cover property (hit && FORCE_TAG_SEL_I ##2 BGND_REQ_O);
   c_tag: cover property ($rose(TAG_OPCODE_O));
   c_reset: cover property (FORCE_RESET_O);
endmodule

// [bench/dbgbk_tb_top.sv]
// Purpose: self-checking bench for dbgbk_top
// Assumes: inputs change on the falling edge
// Notes:   expectations come from the bench model only
`timescale 1ns/100ps
module dbgbk_tb_top;
   import dbgbk_pkg::*;
   logic        CLK_I = 1'b0, SYS_RST_I = 1'b1, USER_WR_FRST_I = 1'b0, BKPT_ENABLE_I = 1'b0;
   logic        FORCE_TAG_SEL_I = 1'b0, CPU_CYCLE_I = 1'b0, CPU_OPCODE_FETCH_I = 1'b0;
   logic        CPU_INSTR_BOUND_I = 1'b0, CPU_EXEC_TAGGED_I = 1'b0, CPU_FLUSH_I = 1'b0;
   logic        CMD_RVALID_O, FORCE_RESET_O, TAG_OPCODE_O, BGND_REQ_O;
   dbgbk_cmd_t  CMD_I;
   dbgbk_addr_t CMD_WDATA_I, CMD_RDATA_O, CPU_ADDR_I = 16'h0000;
   dbgbk_byte_t USER_WDATA_I = 8'h00, FRST_RDATA_O;
   int          n_mismatch = 0, checked = 0, seed = 32'h59C9, i, m;
   always #4 CLK_I = ~CLK_I;
   dbgbk_top  DUT (.*);
   dbgbk_host HOST (.clk_i(CLK_I), .cmd_o(CMD_I), .wdata_o(CMD_WDATA_I));
   task automatic chk(input string nm, input int exp, input logic [15:0] got);
      checked++;
      if (got !== exp[15:0]) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp[15:0], got);
      end
   endtask
   task automatic cpu(input logic cy, fe, bd, ex, fl);
      @(negedge CLK_I);
      {CPU_CYCLE_I, CPU_OPCODE_FETCH_I, CPU_INSTR_BOUND_I, CPU_EXEC_TAGGED_I, CPU_FLUSH_I} = {cy, fe, bd, ex, fl};
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge CLK_I);
      n_mismatch++;
      close_out();
   end
   // -------------------------------------------
   // main sequence
   // -------------------------------------------
   initial begin
      repeat (8) @(negedge CLK_I);
      SYS_RST_I = 1'b0;
      chk("frst_rdata", 0, {8'h00, FRST_RDATA_O});
      for (i = 0; i < 20; i++) begin
         m = $random(seed) & 32'hFFFF;
         HOST.send(DBGBK_CMD_WR_BKPT, m[15:0]);
         HOST.send(DBGBK_CMD_RD_BKPT, 16'h0000);
         HOST.send(DBGBK_CMD_NONE, 16'h0000);
         chk("bkpt_read", m, CMD_RDATA_O);
         chk("rvalid", 1, {15'h0000, CMD_RVALID_O});
      end
      for (i = 0; i < 4; i++) begin
         USER_WR_FRST_I = ~i[0];
         USER_WDATA_I   = $random(seed) | 1;
         HOST.send(DBGBK_CMD_WR_FRST, ($random(seed) & 16'hFFFE) | i[0]);
         HOST.send(DBGBK_CMD_NONE, 16'h0000);
         chk("force_reset", i & 1, {15'h0000, FORCE_RESET_O});
         chk("frst_rdata", 0, {8'h00, FRST_RDATA_O});
      end
      USER_WR_FRST_I = 1'b0;
      // breakpoint loaded while disarmed, as in background mode
      m = $random(seed) & 32'hFFFF;
      HOST.send(DBGBK_CMD_WR_BKPT, m[15:0]);
      CPU_ADDR_I = m[15:0];
      for (i = 0; i < 4; i++) begin
         BKPT_ENABLE_I   = i != 3;
         FORCE_TAG_SEL_I = i == 0;
         cpu(1, 0, 0, 0, 0);
         cpu(0, 1, 0, 0, 0);
         cpu(0, 0, 0, i > 0, i == 2);
         chk("tag", i == 1 || i == 2, {15'h0000, TAG_OPCODE_O});
         chk("bgnd_req", i == 0, {15'h0000, BGND_REQ_O});
         cpu(0, 0, 1, 0, 0);
         chk("bgnd_req", i < 2, {15'h0000, BGND_REQ_O});
         cpu(0, 0, 0, 0, 0);
         chk("bgnd_req", 0, {15'h0000, BGND_REQ_O});
      end
      close_out();
   end
endmodule
bind dbgbk_top dbgbk_props u_props (.*);

// [rtl/dbgbk_map.svh]
// Purpose: constants for the debug breakpoint and force-reset block
// Assumes: included by the package and by dbgbk_top
// Notes:   no offsets exist; only the match register sits outside the memory map
`ifndef DBGBK_MAP_SVH
`define DBGBK_MAP_SVH

`define DBGBK_ADDR_W        16
`define DBGBK_DATA_W        8
`define DBGBK_BKPT_RST      16'h0000
`define DBGBK_FRST_RST      8'h00
`define DBGBK_FRST_READ     8'h00
`define DBGBK_FRST_BIT      0
`define DBGBK_CMD_NONE      2'h0
`define DBGBK_CMD_RD_BKPT   2'h1
`define DBGBK_CMD_WR_BKPT   2'h2
`define DBGBK_CMD_WR_FRST   2'h3

`endif

// [rtl/dbgbk_match.sv]
// Purpose: registered breakpoint address comparator
// Assumes: cpu address valid when bus cycle strobe high
// Notes:   one cycle of latency; hit is a pulse
`timescale 1ns/100ps

module dbgbk_match
   import dbgbk_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        enable_i,
   input  wire dbgbk_addr_t match_addr_i,
   input  wire dbgbk_addr_t cpu_addr_i,
   input  wire logic        cpu_cycle_i,
   output logic             hit_o
);
   import dbgbk_pkg::*;

   wire equal_w;
   wire hit_w;

   // ----------------------------------------
   // compare
   // ----------------------------------------
   // compare every bus cycle, user or background
   assign equal_w = (cpu_addr_i == match_addr_i);
   // enable clear masks the match register entirely
   assign hit_w   = enable_i & cpu_cycle_i & equal_w;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hit_o <= 1'b0;
      end else begin
         hit_o <= hit_w;
      end
   end

endmodule

// [rtl/dbgbk_pkg.sv]
// Purpose: types for the debug breakpoint and force-reset block
// Assumes: dbgbk_map.svh gives the figures
// Notes:   command codes come from the serial command decoder
`include "dbgbk_map.svh"

package dbgbk_pkg;

   typedef logic [`DBGBK_ADDR_W-1:0] dbgbk_addr_t;
   typedef logic [`DBGBK_DATA_W-1:0] dbgbk_byte_t;

   typedef enum logic [1:0] {
      DBGBK_CMD_NONE    = 2'b00,
      DBGBK_CMD_RD_BKPT = 2'b01,
      DBGBK_CMD_WR_BKPT = 2'b10,
      DBGBK_CMD_WR_FRST = 2'b11
   } dbgbk_cmd_t;

   typedef enum logic [1:0] {
      DBGBK_ST_IDLE   = 2'b00,
      DBGBK_ST_TAGGED = 2'b01,
      DBGBK_ST_REQ    = 2'b10
   } dbgbk_state_t;

endpackage

// [rtl/dbgbk_top.sv]
// Purpose: debug breakpoint match register and host force-reset register
// Assumes: serial debug decoder delivers one-cycle command strobes
// Notes:   enable and force/tag bits live in the status/control register
//
// Function
// - 16-bit breakpoint match register compared against cpu address bus.
// - breakpoint enable and force/tag select gate and configure matching.
// - match register reached only by serial read/write breakpoint commands.
// - user program writes to force-reset register are ignored.
// - force-reset register reads zero, resets zero, only bit 0 writable.
// - host writing one to force-reset bit asserts full system reset.
// - enable clear disables breakpoint, ignores force/tag and address.
// - force: request at instruction boundary; tag: request if opcode executes.
`timescale 1ns/100ps
`include "dbgbk_map.svh"

module dbgbk_top
   import dbgbk_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire dbgbk_cmd_t  CMD_I,
   input  wire dbgbk_addr_t CMD_WDATA_I,
   input  wire logic        USER_WR_FRST_I,
   input  wire dbgbk_byte_t USER_WDATA_I,
   input  wire logic        BKPT_ENABLE_I,
   input  wire logic        FORCE_TAG_SEL_I,
   input  wire dbgbk_addr_t CPU_ADDR_I,
   input  wire logic        CPU_CYCLE_I,
   input  wire logic        CPU_OPCODE_FETCH_I,
   input  wire logic        CPU_INSTR_BOUND_I,
   input  wire logic        CPU_EXEC_TAGGED_I,
   input  wire logic        CPU_FLUSH_I,
   output dbgbk_addr_t      CMD_RDATA_O,
   output logic             CMD_RVALID_O,
   output dbgbk_byte_t      FRST_RDATA_O,
   output logic             FORCE_RESET_O,
   output logic             TAG_OPCODE_O,
   output logic             BGND_REQ_O
);
   import dbgbk_pkg::*;

   dbgbk_addr_t  bkpt_ff;
   dbgbk_addr_t  nxt_bkpt;
   dbgbk_state_t state_ff;
   dbgbk_state_t nxt_state;
   logic         tag_ff;
   logic         bgnd_ff;
   logic         frst_ff;

   wire          wr_bkpt_w;
   wire          rd_bkpt_w;
   wire          wr_frst_w;
   wire          hit_w;
   wire          force_hit_w;
   wire          tag_hit_w;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   // only serial strobes reach the match register
   assign wr_bkpt_w = (CMD_I == DBGBK_CMD_WR_BKPT);
   assign rd_bkpt_w = (CMD_I == DBGBK_CMD_RD_BKPT);
   // user write strobe is deliberately never decoded
   assign wr_frst_w = (CMD_I == DBGBK_CMD_WR_FRST) & CMD_WDATA_I[`DBGBK_FRST_BIT];
   assign nxt_bkpt  = wr_bkpt_w ? CMD_WDATA_I : bkpt_ff;

   // ----------------------------------------
   // match register
   // ----------------------------------------
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bkpt_ff <= `DBGBK_BKPT_RST;
      end else begin
         bkpt_ff <= nxt_bkpt;
      end
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         CMD_RDATA_O  <= `DBGBK_BKPT_RST;
         CMD_RVALID_O <= 1'b0;
      end else begin
         CMD_RDATA_O  <= rd_bkpt_w ? bkpt_ff : CMD_RDATA_O;
         CMD_RVALID_O <= rd_bkpt_w;
      end
   end

   // ----------------------------------------
   // force reset
   // ----------------------------------------
   // pulse is one cycle; the system reset it triggers clears it anyway
   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         frst_ff      <= 1'b0;
         FRST_RDATA_O <= `DBGBK_FRST_RST;
      end else begin
         frst_ff      <= wr_frst_w;
         FRST_RDATA_O <= `DBGBK_FRST_READ;
      end
   end
   assign FORCE_RESET_O = frst_ff;

   // ----------------------------------------
   // breakpoint sequencing
   // ----------------------------------------
   dbgbk_match u_match (
      .clk_i        (CLK_I),
      .rst_i        (SYS_RST_I),
      .enable_i     (BKPT_ENABLE_I),
      .match_addr_i (bkpt_ff),
      .cpu_addr_i   (CPU_ADDR_I),
      .cpu_cycle_i  (CPU_CYCLE_I),
      .hit_o        (hit_w)
   );

   // force/tag only matters once enable passed the hit
   assign force_hit_w = hit_w & FORCE_TAG_SEL_I;
   assign tag_hit_w   = hit_w & ~FORCE_TAG_SEL_I & CPU_OPCODE_FETCH_I;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         DBGBK_ST_IDLE: begin
            if (force_hit_w) begin
               nxt_state = DBGBK_ST_REQ;
            end else if (tag_hit_w) begin
               nxt_state = DBGBK_ST_TAGGED;
            end
         end
         DBGBK_ST_TAGGED: begin
            // flushed tag never executes, so no break
            if (CPU_FLUSH_I | ~BKPT_ENABLE_I) begin
               nxt_state = DBGBK_ST_IDLE;
            end else if (CPU_EXEC_TAGGED_I) begin
               nxt_state = DBGBK_ST_REQ;
            end
         end
         DBGBK_ST_REQ: begin
            // request held until the cpu reaches a boundary
            if (CPU_INSTR_BOUND_I) begin
               nxt_state = DBGBK_ST_IDLE;
            end
         end
         default: begin
            nxt_state = DBGBK_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state_ff <= DBGBK_ST_IDLE;
         tag_ff   <= 1'b0;
         bgnd_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tag_ff   <= tag_hit_w & (state_ff == DBGBK_ST_IDLE);
         bgnd_ff  <= (nxt_state == DBGBK_ST_REQ);
      end
   end
   assign TAG_OPCODE_O = tag_ff;
   assign BGND_REQ_O   = bgnd_ff;

endmodule
